// >>> rtl/setup_parameter_editor.sv
// Notes on behaviour
// - Hardcopy speed codes 0..7 pick 110 to 19200 baud; default 6.
// - Mains setting 0 means 60 Hz, 1 means 50 Hz; default from switches.
// - Self-test 1..5 select tests, 9 repeats until failure, 0 clears all.
// - In menu, two-letter code selects; return/right advance, left steps back.
// - Digit loads value directly; space/up next value, down previous value.
// - Navigation wraps; after the last parameter comes transmit speed.
// - Any other key that starts no two-letter code sounds the bell; shown parameter and value stay.
// - Configuration key enters menu, next press leaves and restores view.
// - Host may rewrite every parameter; new values take effect.
// - Transmit speed offers eight rates, 110 to 19200 baud.
// - Receive speed offers the same eight rates.
// - Transmit and receive bit clocks are generated independently.
// - Transmit at 110 baud uses two stop bits, else one.
// - Transmit and receive defaults come from the same switch group.
// - On-line sends keys and shows host; local echoes keys only.
// - Line setting 1 asserts terminal ready; 0 drops it, lights local.
// - Interpreter off: line/local setting alone decides host connection.
// - Interpreter 1: enabled, keyboard feeds it, indicator lit.
// - Interpreter 2: enabled, host line feeds it, indicator lit.
`timescale 1ns/1ps
`include "setup_editor_defs.svh"

module setup_parameter_editor #(
    parameter int CLK_HZ = `CLK_RATE_HZ
) (
    // Clock and reset
    input wire logic i_mclk,
    input wire logic i_rst,
    // Operator side
    input wire logic i_setup_key,
    input wire setup_editor_pkg::key_event_t i_key,
    input wire setup_editor_pkg::switch_pack_t i_switch,
    // Host side
    input wire setup_editor_pkg::host_write_t i_host_wr,
    // Menu and display
    output logic o_menu_active,
    output logic o_restore_view,
    output logic o_bell,
    output logic [2:0] o_disp_idx,
    output logic [3:0] o_disp_value,
    // Applied settings
    output logic o_tx_tick,
    output logic o_rx_tick,
    output logic o_hc_tick,
    output logic o_tx_two_stop,
    output logic o_mains_50hz,
    output logic o_interlace,
    output logic [4:0] o_test_sel,
    output logic o_test_repeat,
    output setup_editor_pkg::line_mode_t o_mode
);

    // Largest legal value of a parameter
    function automatic logic [3:0] val_max(input logic [2:0] idx);
        unique case (idx)
            `PIDX_XMIT, `PIDX_RECV, `PIDX_HCOPY: val_max = `MAX_RATE;
            `PIDX_INTERP: val_max = `MAX_INTERP;
            `PIDX_TEST: val_max = `TEST_REPEAT;
            default: val_max = `MAX_BIN;
        endcase
    endfunction

    // Self-test accepts 0..5 and 9 only
    function automatic logic val_legal(input logic [2:0] idx, input logic [3:0] v);
        if (idx == `PIDX_TEST)
            val_legal = (v <= `TEST_LAST_SEL) || (v == `TEST_REPEAT);
        else
            val_legal = (v <= val_max(idx));
    endfunction

    // Next permitted value, wrapping
    function automatic logic [3:0] val_up(input logic [2:0] idx, input logic [3:0] v);
        if (idx == `PIDX_TEST && v == `TEST_LAST_SEL)
            val_up = `TEST_REPEAT;
        else if (v == val_max(idx))
            val_up = 4'h0;
        else
            val_up = 4'(v + 4'h1);
    endfunction

    // Previous permitted value, wrapping
    function automatic logic [3:0] val_down(input logic [2:0] idx, input logic [3:0] v);
        if (idx == `PIDX_TEST && v == `TEST_REPEAT)
            val_down = `TEST_LAST_SEL;
        else if (v == 4'h0)
            val_down = val_max(idx);
        else
            val_down = 4'(v - 4'h1);
    endfunction

    // Two-letter code of each parameter
    function automatic logic [15:0] code_of(input logic [2:0] idx);
        unique case (idx)
            `PIDX_XMIT: code_of = `CODE_XMIT;
            `PIDX_RECV: code_of = `CODE_RECV;
            `PIDX_LINE: code_of = `CODE_LINE;
            `PIDX_INTERP: code_of = `CODE_INTERP;
            `PIDX_HCOPY: code_of = `CODE_HCOPY;
            `PIDX_MAINS: code_of = `CODE_MAINS;
            `PIDX_ILACE: code_of = `CODE_ILACE;
            default: code_of = `CODE_TEST;
        endcase
    endfunction

    // Cycles per bit minus one for a rate code
    function automatic logic [23:0] rate_div(input logic [2:0] r);
        int baud;
        unique case (r)
            3'h0: baud = `BAUD_0;
            3'h1: baud = `BAUD_1;
            3'h2: baud = `BAUD_2;
            3'h3: baud = `BAUD_3;
            3'h4: baud = `BAUD_4;
            3'h5: baud = `BAUD_5;
            3'h6: baud = `BAUD_6;
            default: baud = `BAUD_7;
        endcase
        rate_div = 24'(CLK_HZ / baud - 1);
    endfunction

    logic [3:0] param_reg [8];
    logic [2:0] cur_idx_reg;
    logic menu_reg;
    logic restore_reg;
    logic bell_reg;
    logic [3:0] disp_value_reg;
    logic [7:0] first_letter_reg;
    setup_editor_pkg::nav_state_t nav_reg;
    setup_editor_pkg::switch_pack_t sw_meta_reg;
    setup_editor_pkg::switch_pack_t sw_sync_reg;
    logic [4:0] test_sel_reg;
    logic test_repeat_reg;
    logic [23:0] tick_cnt_reg [3];
    logic [2:0] tick_reg;
    logic two_stop_reg;
    logic mains_reg;
    logic ilace_reg;
    setup_editor_pkg::line_mode_t mode_reg;

    logic [3:0] cur_val;
    logic nav_next;
    logic nav_prev;
    logic nav_jump;
    logic [2:0] jump_idx;
    logic val_wr;
    logic [3:0] val_new;
    logic bell_next;
    logic letter_hold;
    logic host_ok;
    logic test_wr;
    logic [3:0] test_val;
    logic [2:0] rate_code [3];

    assign cur_val = param_reg[cur_idx_reg];
    assign host_ok = i_host_wr.valid && val_legal(i_host_wr.idx, i_host_wr.value);

    // Switch pack pins pass two flip-flops
    always_ff @(posedge i_mclk)
    begin
        sw_meta_reg <= i_switch;
        sw_sync_reg <= sw_meta_reg;
    end

    // Menu key decode
    always_comb
    begin
        nav_next = 1'b0;
        nav_prev = 1'b0;
        nav_jump = 1'b0;
        jump_idx = 3'h0;
        val_wr = 1'b0;
        val_new = cur_val;
        bell_next = 1'b0;
        letter_hold = 1'b0;
        if (menu_reg && i_key.valid && !i_setup_key)
        begin
            if (i_key.code == `KEY_CR || i_key.code == `KEY_RIGHT)
                nav_next = 1'b1;
            else if (i_key.code == `KEY_LEFT)
                nav_prev = 1'b1;
            else if (i_key.code == `KEY_SPACE || i_key.code == `KEY_UP)
            begin
                val_wr = 1'b1;
                val_new = val_up(cur_idx_reg, cur_val);
            end
            else if (i_key.code == `KEY_DOWN)
            begin
                val_wr = 1'b1;
                val_new = val_down(cur_idx_reg, cur_val);
            end
            else if (i_key.code[7:4] == `KEY_DIGIT_HI && i_key.code[3:0] <= `KEY_DIGIT_MAX)
            begin
                val_wr = val_legal(cur_idx_reg, i_key.code[3:0]);
                val_new = i_key.code[3:0];
                bell_next = !val_wr;
            end
            else
            begin
                for (int i = 0; i < 8; i++)
                begin
                    if (nav_reg == setup_editor_pkg::NAV_SECOND &&
                        code_of(3'(i)) == {first_letter_reg, i_key.code})
                    begin
                        nav_jump = 1'b1;
                        jump_idx = 3'(i);
                    end
                    if ((code_of(3'(i)) & 16'hFF00) == {i_key.code, 8'h00})
                        letter_hold = 1'b1;
                end
                if (nav_jump)
                    letter_hold = 1'b0;
                bell_next = !nav_jump && !letter_hold;
            end
        end
    end

    // Menu on and off, view restore pulse
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            menu_reg <= 1'b0;
            restore_reg <= 1'b0;
        end
        else
        begin
            menu_reg <= menu_reg ^ i_setup_key;
            restore_reg <= menu_reg && i_setup_key;
        end
    end

    // Current parameter and letter pairing
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            cur_idx_reg <= `PIDX_XMIT;
            nav_reg <= setup_editor_pkg::NAV_IDLE;
            first_letter_reg <= 8'h00;
        end
        else
        begin
            if (nav_next)
                cur_idx_reg <= 3'(cur_idx_reg + 3'h1);
            else if (nav_prev)
                cur_idx_reg <= 3'(cur_idx_reg - 3'h1);
            else if (nav_jump)
                cur_idx_reg <= jump_idx;
            if (menu_reg && i_key.valid)
            begin
                nav_reg <= letter_hold ? setup_editor_pkg::NAV_SECOND : setup_editor_pkg::NAV_IDLE;
                first_letter_reg <= i_key.code;
            end
            else if (!menu_reg)
                nav_reg <= setup_editor_pkg::NAV_IDLE;
        end
    end

    // Parameter storage; host write wins on the same parameter
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            param_reg[`PIDX_XMIT] <= {1'b0, sw_sync_reg.rate};
            param_reg[`PIDX_RECV] <= {1'b0, sw_sync_reg.rate};
            param_reg[`PIDX_LINE] <= `DEF_LINE;
            param_reg[`PIDX_INTERP] <= `DEF_INTERP;
            param_reg[`PIDX_HCOPY] <= `DEF_HCOPY;
            param_reg[`PIDX_MAINS] <= {3'h0, sw_sync_reg.mains};
            param_reg[`PIDX_ILACE] <= `DEF_ILACE;
            param_reg[`PIDX_TEST] <= `DEF_TEST;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (host_ok && i_host_wr.idx == 3'(i))
                    param_reg[i] <= i_host_wr.value;
                else if (val_wr && cur_idx_reg == 3'(i))
                    param_reg[i] <= val_new;
            end
        end
    end

    // Self-test selections
    assign test_wr = (host_ok && i_host_wr.idx == `PIDX_TEST) || (val_wr && cur_idx_reg == `PIDX_TEST);
    assign test_val = (host_ok && i_host_wr.idx == `PIDX_TEST) ? i_host_wr.value : val_new;

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            test_sel_reg <= 5'h00;
            test_repeat_reg <= 1'b0;
        end
        else if (test_wr)
        begin
            if (test_val == `TEST_CLEAR)
            begin
                test_sel_reg <= 5'h00;
                test_repeat_reg <= 1'b0;
            end
            else if (test_val == `TEST_REPEAT)
                test_repeat_reg <= 1'b1;
            else
                test_sel_reg[test_val[2:0] - 3'h1] <= 1'b1;
        end
    end

    // Bell and displayed value
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            bell_reg <= 1'b0;
            disp_value_reg <= 4'h0;
        end
        else
        begin
            bell_reg <= bell_next;
            disp_value_reg <= cur_val;
        end
    end

    // Independent bit clocks: transmit, receive, hardcopy
    assign rate_code[0] = param_reg[`PIDX_XMIT][2:0];
    assign rate_code[1] = param_reg[`PIDX_RECV][2:0];
    assign rate_code[2] = param_reg[`PIDX_HCOPY][2:0];

    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            for (int k = 0; k < 3; k++)
                tick_cnt_reg[k] <= 24'h000000;
            tick_reg <= 3'h0;
        end
        else
        begin
            for (int k = 0; k < 3; k++)
            begin
                if (tick_cnt_reg[k] >= rate_div(rate_code[k]))
                begin
                    tick_cnt_reg[k] <= 24'h000000;
                    tick_reg[k] <= 1'b1;
                end
                else
                begin
                    tick_cnt_reg[k] <= 24'(tick_cnt_reg[k] + 24'h000001);
                    tick_reg[k] <= 1'b0;
                end
            end
        end
    end

    // Applied modes from the stored values
    always_ff @(posedge i_mclk)
    begin
        if (i_rst)
        begin
            two_stop_reg <= 1'b0;
            mains_reg <= 1'b0;
            ilace_reg <= 1'b0;
            mode_reg <= '0;
        end
        else
        begin
            two_stop_reg <= rate_code[0] == `RATE_SLOWEST;
            mains_reg <= param_reg[`PIDX_MAINS][0];
            ilace_reg <= param_reg[`PIDX_ILACE][0];
            mode_reg.dtr <= param_reg[`PIDX_LINE] == `LINE_ONLINE;
            mode_reg.online_led <= param_reg[`PIDX_LINE] == `LINE_ONLINE;
            mode_reg.local_led <= param_reg[`PIDX_LINE] != `LINE_ONLINE;
            mode_reg.kbd_to_host <= param_reg[`PIDX_LINE] == `LINE_ONLINE &&
                param_reg[`PIDX_INTERP] != `INTERP_KBD;
            mode_reg.host_to_screen <= param_reg[`PIDX_LINE] == `LINE_ONLINE &&
                param_reg[`PIDX_INTERP] != `INTERP_HOST;
            mode_reg.local_echo <= param_reg[`PIDX_LINE] != `LINE_ONLINE &&
                param_reg[`PIDX_INTERP] == `INTERP_OFF;
            mode_reg.interp_en <= param_reg[`PIDX_INTERP] != `INTERP_OFF;
            mode_reg.interp_led <= param_reg[`PIDX_INTERP] != `INTERP_OFF;
            mode_reg.kbd_to_interp <= param_reg[`PIDX_INTERP] == `INTERP_KBD;
            mode_reg.host_to_interp <= param_reg[`PIDX_INTERP] == `INTERP_HOST;
        end
    end

    // Output drive
    assign o_menu_active = menu_reg;
    assign o_restore_view = restore_reg;
    assign o_bell = bell_reg;
    assign o_disp_idx = cur_idx_reg;
    assign o_disp_value = disp_value_reg;
    assign o_tx_tick = tick_reg[0];
    assign o_rx_tick = tick_reg[1];
    assign o_hc_tick = tick_reg[2];
    assign o_tx_two_stop = two_stop_reg;
    assign o_mains_50hz = mains_reg;
    assign o_interlace = ilace_reg;
    assign o_test_sel = test_sel_reg;
    assign o_test_repeat = test_repeat_reg;
    assign o_mode = mode_reg;

    // Checks
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    sequence menu_key(logic [7:0] c);
        menu_reg && !i_setup_key && i_key.valid && i_key.code == c;
    endsequence

    sequence letter_pair(logic [15:0] pair);
        menu_key(pair[15:8]) ##1 menu_key(pair[7:0]);
    endsequence

    stop_bits_a: assert property (
        ##1 o_tx_two_stop == ($past(param_reg[`PIDX_XMIT]) == 4'h0))
        else $error("stop bit count does not follow transmit rate");

    ready_local_a: assert property (
        !$past(i_rst) |-> o_mode.dtr != o_mode.local_led && o_mode.dtr == o_mode.online_led)
        else $error("terminal ready and local indicator disagree");

    nav_wrap_a: assert property (
        menu_key(`KEY_RIGHT) and (cur_idx_reg == `PIDX_LAST) |=> cur_idx_reg == `PIDX_XMIT)
        else $error("navigation did not wrap to transmit speed");

    nav_back_a: assert property (
        menu_key(`KEY_LEFT) |=> cur_idx_reg == 3'($past(cur_idx_reg) - 3'h1))
        else $error("left key did not step back");

    code_select_a: assert property (
        letter_pair(`CODE_MAINS) |=> cur_idx_reg == `PIDX_MAINS)
        else $error("two-letter code did not select parameter");

    bad_key_a: assert property (
        menu_key(8'h7E) and !host_ok |=> o_bell && $stable(cur_idx_reg) && $stable(param_reg[cur_idx_reg]))
        else $error("stray key did not ring bell or changed state");

    digit_load_a: assert property (
        menu_key(8'h31) and !(host_ok && i_host_wr.idx == cur_idx_reg)
        |=> param_reg[$past(cur_idx_reg)] == 4'h1)
        else $error("typed digit not loaded");

    menu_leave_a: assert property (
        menu_reg && i_setup_key |=> !menu_reg && o_restore_view ##1 !o_restore_view)
        else $error("menu did not close with one view restore pulse");

    host_apply_a: assert property (
        host_ok |=> param_reg[$past(i_host_wr.idx)] == $past(i_host_wr.value))
        else $error("host write not applied");

    interp_route_a: assert property (
        param_reg[`PIDX_INTERP] == `INTERP_HOST ##1 param_reg[`PIDX_INTERP] == `INTERP_HOST
        |-> o_mode.interp_led && o_mode.host_to_interp && !o_mode.kbd_to_interp)
        else $error("host interpreter routing wrong");

    test_clear_a: assert property (
        test_wr && test_val == `TEST_CLEAR |=> o_test_sel == 5'h00 && !o_test_repeat)
        else $error("self-test clear left selections");

endmodule

// >>> rtl/setup_editor_defs.svh
`ifndef SETUP_EDITOR_DEFS_SVH
`define SETUP_EDITOR_DEFS_SVH

// System clock rate in Hz (8 ns period)
`define CLK_RATE_HZ 125000000

// Parameter positions in menu order
`define PIDX_XMIT 3'h0
`define PIDX_RECV 3'h1
`define PIDX_LINE 3'h2
`define PIDX_INTERP 3'h3
`define PIDX_HCOPY 3'h4
`define PIDX_MAINS 3'h5
`define PIDX_ILACE 3'h6
`define PIDX_TEST 3'h7
`define PIDX_LAST 3'h7

// Two-letter codes, first letter in the upper byte
`define CODE_XMIT 16'h5453
`define CODE_RECV 16'h5253
`define CODE_LINE 16'h4C4C
`define CODE_INTERP 16'h4241
`define CODE_HCOPY 16'h4853
`define CODE_MAINS 16'h5046
`define CODE_ILACE 16'h494C
`define CODE_TEST 16'h5354

// Reset values not taken from the switch pack
`define DEF_HCOPY 4'h6
`define DEF_LINE 4'h1
`define DEF_INTERP 4'h0
`define DEF_ILACE 4'h0
`define DEF_TEST 4'h0

// Largest legal setting of each kind, self-test clear code, slowest rate code
`define MAX_RATE 4'h7
`define MAX_BIN 4'h1
`define MAX_INTERP 4'h2
`define TEST_LAST_SEL 4'h5
`define TEST_REPEAT 4'h9
`define TEST_CLEAR 4'h0
`define RATE_SLOWEST 3'h0

// Line/local and interpreter settings
`define LINE_ONLINE 4'h1
`define INTERP_OFF 4'h0
`define INTERP_KBD 4'h1
`define INTERP_HOST 4'h2

// Baud rates for rate codes 0 to 7
`define BAUD_0 110
`define BAUD_1 300
`define BAUD_2 600
`define BAUD_3 1200
`define BAUD_4 2400
`define BAUD_5 4800
`define BAUD_6 9600
`define BAUD_7 19200

// Key codes
`define KEY_CR 8'h0D
`define KEY_SPACE 8'h20
`define KEY_UP 8'h80
`define KEY_DOWN 8'h81
`define KEY_RIGHT 8'h82
`define KEY_LEFT 8'h83
`define KEY_DIGIT_HI 4'h3
`define KEY_DIGIT_MAX 4'h9

`endif

// >>> rtl/setup_editor_pkg.sv
package setup_editor_pkg;

    typedef logic [3:0] param_value_t;

    typedef struct packed {
        logic valid;
        logic [7:0] code;
    } key_event_t;

    typedef struct packed {
        logic valid;
        logic [2:0] idx;
        logic [3:0] value;
    } host_write_t;

    typedef struct packed {
        logic [2:0] rate;
        logic mains;
    } switch_pack_t;

    typedef struct packed {
        logic dtr;
        logic online_led;
        logic local_led;
        logic kbd_to_host;
        logic host_to_screen;
        logic local_echo;
        logic interp_en;
        logic interp_led;
        logic kbd_to_interp;
        logic host_to_interp;
    } line_mode_t;

    typedef enum logic {NAV_IDLE, NAV_SECOND} nav_state_t;

endpackage

// >>> bench/host_line_model.sv
`timescale 1ns/1ps

module host_line_model (
    // Clock
    input wire logic i_mclk,
    // Write requests from the bench
    input wire setup_editor_pkg::host_write_t i_req,
    // Rate ticks: transmit, receive, hardcopy
    input wire logic [2:0] i_ticks,
    // Line side of the host
    output setup_editor_pkg::host_write_t o_host_wr,
    output logic [2:0][15:0] o_period
);
    logic [2:0][15:0] cnt_reg = '0;

    // Host sends parameter rewrites down the line
    assign o_host_wr = i_req;

    // Cycles between successive ticks of each rate
    always_ff @(posedge i_mclk)
    begin
        for (int i = 0; i < 3; i++)
        begin
            if (i_ticks[i])
            begin
                cnt_reg[i] <= '0;
                o_period[i] <= cnt_reg[i] + 16'h0001;
            end
            else
            begin
                cnt_reg[i] <= cnt_reg[i] + 16'h0001;
            end
        end
    end
endmodule

// >>> bench/tb_setup_parameter_editor.sv
`timescale 1ns/1ps

module tb_setup_parameter_editor;
    localparam int CLK_HZ = 110000;
    localparam int BAUD [8] = '{110, 300, 600, 1200, 2400, 4800, 9600, 19200};
    logic i_mclk = 1'b0;
    logic i_rst = 1'b1;
    logic i_setup_key = 1'b0;
    setup_editor_pkg::key_event_t i_key = '0;
    setup_editor_pkg::switch_pack_t i_switch = 4'h7;
    setup_editor_pkg::host_write_t req = '0;
    setup_editor_pkg::host_write_t i_host_wr;
    setup_editor_pkg::line_mode_t o_mode;
    logic o_menu_active, o_restore_view, o_bell, o_tx_tick, o_rx_tick, o_hc_tick;
    logic o_tx_two_stop, o_mains_50hz, o_interlace, o_test_repeat;
    logic [2:0] o_disp_idx;
    logic [3:0] o_disp_value;
    logic [4:0] o_test_sel;
    logic [2:0][15:0] period;
    logic bell_seen, restore_seen;
    int n_mismatch = 0;
    int samples_checked = 0;
    int cycles = 0;

    setup_parameter_editor #(.CLK_HZ(CLK_HZ)) dut_u (.i_mclk(i_mclk), .i_rst(i_rst),
        .i_setup_key(i_setup_key), .i_key(i_key), .i_switch(i_switch), .i_host_wr(i_host_wr),
        .o_menu_active(o_menu_active), .o_restore_view(o_restore_view), .o_bell(o_bell),
        .o_disp_idx(o_disp_idx), .o_disp_value(o_disp_value), .o_tx_tick(o_tx_tick),
        .o_rx_tick(o_rx_tick), .o_hc_tick(o_hc_tick), .o_tx_two_stop(o_tx_two_stop),
        .o_mains_50hz(o_mains_50hz), .o_interlace(o_interlace), .o_test_sel(o_test_sel),
        .o_test_repeat(o_test_repeat), .o_mode(o_mode));

    host_line_model host_u (.i_mclk(i_mclk), .i_req(req), .i_ticks({o_hc_tick, o_rx_tick, o_tx_tick}),
        .o_host_wr(i_host_wr), .o_period(period));

    // 125 MHz clock
    always #4 i_mclk = ~i_mclk;

    // Hang guard
    always @(posedge i_mclk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_mismatch++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string msg);
        samples_checked++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("mismatch at %0t: %s got %0h want %0h", $time, msg, got, exp);
        end
    endtask

    // One key event, then room for display update
    task automatic press(input logic [7:0] code);
        @(negedge i_mclk);
        i_key = {1'b1, code};
        @(negedge i_mclk);
        i_key = '0;
        bell_seen = o_bell;
        repeat (2) @(negedge i_mclk);
    endtask

    // Two key events on consecutive edges
    task automatic press_pair(input logic [15:0] pair);
        @(negedge i_mclk);
        i_key = {1'b1, pair[15:8]};
        @(negedge i_mclk);
        i_key = {1'b1, pair[7:0]};
        @(negedge i_mclk);
        i_key = '0;
        repeat (2) @(negedge i_mclk);
    endtask

    task automatic setup_press();
        @(negedge i_mclk);
        i_setup_key = 1'b1;
        @(negedge i_mclk);
        i_setup_key = 1'b0;
        restore_seen = o_restore_view;
        repeat (2) @(negedge i_mclk);
    endtask

    task automatic host_write(input logic [2:0] idx, input logic [3:0] value);
        @(negedge i_mclk);
        req = {1'b1, idx, value};
        @(negedge i_mclk);
        req = '0;
        repeat (2) @(negedge i_mclk);
    endtask

    // Main sequence
    initial
    begin
        repeat (12) @(negedge i_mclk);
        i_rst = 1'b0;
        repeat (3) @(negedge i_mclk);
        check(o_menu_active, 1'b0, "menu after reset");
        check(o_mains_50hz, 1'b1, "mains default");
        check(o_mode.dtr, 1'b1, "ready default");
        check(o_tx_two_stop, 1'b0, "stop default");
        check(o_test_sel, 5'h00, "tests default");
        repeat (2600) @(negedge i_mclk);
        check(period[0], CLK_HZ / BAUD[3], "tx default");
        check(period[1], CLK_HZ / BAUD[3], "rx default");
        check(period[2], CLK_HZ / BAUD[6], "hc default");
        press("P");
        press("F");
        check(o_disp_idx, 3'h0, "keys with menu closed");
        setup_press();
        check(o_menu_active, 1'b1, "menu open");
        press_pair(16'h5046);
        check(o_disp_idx, 3'h5, "code select");
        check(o_disp_value, 4'h1, "mains shown");
        press("0");
        check(o_mains_50hz, 1'b0, "digit load");
        press(8'h80);
        check(o_mains_50hz, 1'b1, "up");
        press(8'h81);
        check(o_mains_50hz, 1'b0, "down");
        press(8'h82);
        check(o_disp_idx, 3'h6, "right");
        press(8'h83);
        check(o_disp_idx, 3'h5, "left");
        press("~");
        check(bell_seen, 1'b1, "bell on stray key");
        check(o_disp_idx, 3'h5, "index kept");
        press("7");
        check(bell_seen, 1'b1, "bell on bad digit");
        check(o_mains_50hz, 1'b0, "value kept");
        press("S");
        press("T");
        press("3");
        check(o_test_sel, 5'h04, "test 3");
        press("1");
        check(o_test_sel, 5'h05, "test 1 added");
        press("9");
        check(o_test_repeat, 1'b1, "repeat");
        press("0");
        check({o_test_repeat, o_test_sel}, 6'h00, "clear");
        press(8'h0D);
        check(o_disp_idx, 3'h0, "wrap forward");
        press(8'h83);
        check(o_disp_idx, 3'h7, "wrap back");
        press(8'h82);
        check(o_disp_idx, 3'h0, "wrap right");
        for (int r = 0; r < 8; r++)
        begin
            press(8'h30 + 8'(r));
            host_write(3'h1, 4'(7 - r));
            host_write(3'h4, 4'(r));
            repeat (2600) @(negedge i_mclk);
            check(period[0], CLK_HZ / BAUD[r], "tx rate");
            check(period[1], CLK_HZ / BAUD[7 - r], "rx rate");
            check(period[2], CLK_HZ / BAUD[r], "hc rate");
            check(o_tx_two_stop, (r == 0), "stop bits");
        end
        setup_press();
        check(o_menu_active, 1'b0, "menu closed");
        check(restore_seen, 1'b1, "view restored");
        host_write(3'h2, 4'h0);
        check({o_mode.dtr, o_mode.local_led, o_mode.local_echo, o_mode.kbd_to_host}, 4'h6, "local");
        host_write(3'h2, 4'h1);
        check({o_mode.dtr, o_mode.kbd_to_host, o_mode.host_to_screen, o_mode.local_echo}, 4'hE, "online");
        host_write(3'h3, 4'h1);
        check({o_mode.interp_en, o_mode.interp_led, o_mode.kbd_to_interp}, 3'h7, "interp kbd");
        host_write(3'h3, 4'h2);
        check({o_mode.interp_en, o_mode.interp_led, o_mode.host_to_interp}, 3'h7, "interp host");
        host_write(3'h3, 4'h5);
        check(o_mode.host_to_interp, 1'b1, "bad host value");
        host_write(3'h3, 4'h0);
        check({o_mode.interp_en, o_mode.interp_led, o_mode.kbd_to_host}, 3'h1, "interp off");
        host_write(3'h6, 4'h1);
        check(o_interlace, 1'b1, "host interlace");
        give_verdict();
    end
endmodule
